// ==== dspt_pkg.sv ====
/*
  Constants shared by the display sync and palette timing block: register
  indices, field positions, byte-lane codes, reset values and palette size.
  Assumes a 16-bit register port with two byte enables.
*/
`default_nettype none

package dspt_pkg;

  // Register indices on the plain register port.
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_HSYNC = 4'h0;
  localparam logic [3:0] REG_VSYNC = 4'h1;
  localparam logic [3:0] REG_BLANK = 4'h2;
  localparam logic [3:0] REG_PALCTL = 4'h3;
  localparam logic [3:0] REG_PALWR = 4'h4;
  localparam logic [3:0] REG_PALRD = 4'h5;
  localparam logic [3:0] REG_LEAD = 4'h6;
  localparam logic [3:0] REG_CTRL3 = 4'h7;

  // Every register resets to zero.
  localparam logic [15:0] REG_RST = 16'h0000;

  // Byte-lane slices of a 16-bit register.
  localparam int HI_MSB = 15;
  localparam int HI_LSB = 8;
  localparam int LO_MSB = 7;
  localparam int LO_LSB = 0;

  // Palette control fields.
  localparam int PAL_EN_BIT = 15;
  localparam int PAL_BUSY_BIT = 14;
  localparam int PAL_TRIG_BIT = 9;
  localparam int PAL_ACC_BIT = 8;
  localparam logic [3:0] PAL_RSVD = 4'h0;

  // Third control register output-enable bits.
  localparam int HS_OE_BIT = 0;
  localparam int VS_OE_BIT = 1;

  // Byte-enable lanes.
  localparam int BE_LO_BIT = 0;
  localparam int BE_HI_BIT = 1;

  // Palette geometry and pass-through fill.
  localparam int PAL_DEPTH = 256;
  localparam int PAL_IW = 8;
  localparam logic [7:0] PIX_FILL = 8'h00;

  // Palette access sequencer.
  typedef enum logic [1:0] {
    DSPT_PAL_IDLE = 2'b00,
    DSPT_PAL_RD = 2'b01,
    DSPT_PAL_WR = 2'b10
  } dspt_pal_op_e;

endpackage

`default_nettype wire

// ==== dspt_timing.sv ====
/*
  Display sync, blanking, interrupt-advance and palette access logic.
  Assumes the pixel clock arrives from outside the core clock domain, and
  that total and active sizes, pixel indices and the power request come
  from logic on core_clk_i.
*/
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Hsync lasts hsync_width display clocks.
// - Hsync moves only with its enable.
// - Hsync starts hsync_start_delay after blanking.
// - Vsync lasts vsync_width lines.
// - Vsync moves only with its enable.
// - Vsync starts vsync_start_delay lines after blanking.
// - First line at first_line_offset after blanking.
// - First pixel at first_pixel_offset clocks.
// - Palette enable translates pixels through palette.
// - Busy flag shows palette access running.
// - Access enable locks display out of palette.
// - Trigger rise reads entry when access enabled.
// - Word or high-byte write stores palette entry.
// - Low-byte write only updates the register.
// - Write value times panel power changes.
// - Read register holds last triggered entry.
// - Eight-bit index selects the palette entry.
// - Vertical interrupt leads vertical blanking.
// - Horizontal interrupt leads horizontal blanking.
module dspt_timing
  import dspt_pkg::*;
#(
  parameter int CNT_W = 11
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [1:0] reg_be_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  input wire logic pixel_clock_i,
  input wire logic [CNT_W-1:0] total_width_i,
  input wire logic [CNT_W-1:0] total_height_i,
  input wire logic [CNT_W-1:0] active_width_i,
  input wire logic [CNT_W-1:0] active_height_i,
  input wire logic [PAL_IW-1:0] pixel_index_i,
  input wire logic power_request_i,
  output logic hsync_o,
  output logic vsync_o,
  output logic display_enable_o,
  output logic [15:0] pixel_color_o,
  output logic hblank_irq_o,
  output logic vblank_irq_o,
  output logic panel_power_control_o
);

  // Offsets are eight bits wide, so counters no wider than that cannot
  // reach every programmed position.
  generate
    if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
      $error("CNT_W must lie between 9 and 16");
    end
  endgenerate

  localparam int SW = CNT_W + 1;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [CNT_W-1:0] hcnt;
    logic [CNT_W-1:0] vcnt;
    logic [15:0] hs;
    logic [15:0] vs;
    logic [15:0] bl;
    logic [15:0] lead;
    logic pal_en;
    logic pal_trig;
    logic pal_acc;
    logic [PAL_IW-1:0] pal_idx;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic hs_oe;
    logic vs_oe;
    dspt_pal_op_e pal_op;
    logic hsync;
    logic vsync;
    logic hirq;
    logic virq;
    logic de;
    logic [15:0] color;
    logic pwr;
    logic [15:0] pwr_cnt;
    logic [15:0] rdata;
  } dspt_state_s;

  dspt_state_s st;
  dspt_state_s next_st;

  // The palette lives beside the state record; folding 4 kbit into one
  // packed vector would only slow simulation down.
  logic [15:0] pal_mem [PAL_DEPTH];
  logic [15:0] pal_word;
  logic [15:0] pix_word;
  logic [15:0] ctl_word;
  logic tick;
  logic rd_go;
  logic wr_go;
  logic h_tot_end;
  logic v_tot_end;
  logic [SW-1:0] hs_end;
  logic [SW-1:0] vs_end;
  logic [SW-1:0] de_hend;
  logic [SW-1:0] de_vend;
  logic [CNT_W-1:0] h_lead_pos;
  logic [CNT_W-1:0] v_lead_pos;
  logic [15:0] wtmp;

  // Merge write data into a register under the byte enables.
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] data,
    input logic [1:0] be
  );
    logic [15:0] r;
    r = old;
    if (be[BE_HI_BIT]) begin
      r[HI_MSB:HI_LSB] = data[HI_MSB:HI_LSB];
    end
    if (be[BE_LO_BIT]) begin
      r[LO_MSB:LO_LSB] = data[LO_MSB:LO_LSB];
    end
    return r;
  endfunction

  // Palette read ports: software entry and display lookup.
  assign pal_word = pal_mem[st.pal_idx];
  assign pix_word = pal_mem[pixel_index_i];

  // Palette control as software sees it; reserved bits read zero.
  assign ctl_word = {st.pal_en, (st.pal_op != DSPT_PAL_IDLE), PAL_RSVD,
                     st.pal_trig, st.pal_acc, st.pal_idx};

  // Next-state logic for the whole block.
  always_comb begin
    next_st = st;
    wtmp = REG_RST;
    rd_go = 1'b0;
    wr_go = 1'b0;

    // Two flops bring the pixel clock in; edges are found past them.
    next_st.sync1 = pixel_clock_i;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    tick = st.sync2 & ~st.prev;

    // Register writes; unmapped and read-only indices are ignored.
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_HSYNC: next_st.hs = merge16(st.hs, reg_wdata_i, reg_be_i);
        REG_VSYNC: next_st.vs = merge16(st.vs, reg_wdata_i, reg_be_i);
        REG_BLANK: next_st.bl = merge16(st.bl, reg_wdata_i, reg_be_i);
        REG_LEAD: next_st.lead = merge16(st.lead, reg_wdata_i, reg_be_i);
        REG_PALCTL: begin
          wtmp = merge16(ctl_word, reg_wdata_i, reg_be_i);
          next_st.pal_en = wtmp[PAL_EN_BIT];
          next_st.pal_trig = wtmp[PAL_TRIG_BIT];
          next_st.pal_acc = wtmp[PAL_ACC_BIT];
          next_st.pal_idx = wtmp[LO_MSB:LO_LSB];
          rd_go = wtmp[PAL_TRIG_BIT] & ~st.pal_trig & wtmp[PAL_ACC_BIT];
        end
        REG_PALWR: begin
          next_st.wdat = merge16(st.wdat, reg_wdata_i, reg_be_i);
          wr_go = reg_be_i[BE_HI_BIT];
        end
        REG_CTRL3: begin
          if (reg_be_i[BE_LO_BIT]) begin
            next_st.hs_oe = reg_wdata_i[HS_OE_BIT];
            next_st.vs_oe = reg_wdata_i[VS_OE_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // Palette access sequencer: one busy cycle per request.
    unique case (st.pal_op)
      DSPT_PAL_IDLE: next_st.pal_op = DSPT_PAL_IDLE;
      DSPT_PAL_RD: begin
        next_st.rdat = pal_word;
        next_st.pal_op = DSPT_PAL_IDLE;
      end
      DSPT_PAL_WR: next_st.pal_op = DSPT_PAL_IDLE;
      default: next_st.pal_op = DSPT_PAL_IDLE;
    endcase
    if (rd_go) begin
      next_st.pal_op = DSPT_PAL_RD;
    end else if (wr_go) begin
      next_st.pal_op = DSPT_PAL_WR;
    end

    // Read data stand only in the cycle after the strobe.
    next_st.rdata = REG_RST;
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_HSYNC: next_st.rdata = st.hs;
        REG_VSYNC: next_st.rdata = st.vs;
        REG_BLANK: next_st.rdata = st.bl;
        REG_PALCTL: next_st.rdata = ctl_word;
        REG_PALWR: next_st.rdata = st.wdat;
        REG_PALRD: next_st.rdata = st.rdat;
        REG_LEAD: next_st.rdata = st.lead;
        REG_CTRL3: next_st.rdata = {14'h0000, st.vs_oe, st.hs_oe};
        default: next_st.rdata = REG_RST;
      endcase
    end

    // Position counters advance once per display clock; zero is the
    // first clock of blanking.
    h_tot_end = ({1'b0, st.hcnt} + SW'(1)) >= {1'b0, total_width_i};
    v_tot_end = ({1'b0, st.vcnt} + SW'(1)) >= {1'b0, total_height_i};
    if (tick) begin
      if (h_tot_end) begin
        next_st.hcnt = '0;
        next_st.vcnt = v_tot_end ? '0 : CNT_W'(st.vcnt + CNT_W'(1));
      end else begin
        next_st.hcnt = CNT_W'(st.hcnt + CNT_W'(1));
      end
    end

    // Sync windows, measured from the counters just computed.
    hs_end = SW'(st.hs[LO_MSB:LO_LSB]) + SW'(st.hs[HI_MSB:HI_LSB]);
    vs_end = SW'(st.vs[LO_MSB:LO_LSB]) + SW'(st.vs[HI_MSB:HI_LSB]);
    next_st.hsync = next_st.hs_oe
                  && ({1'b0, next_st.hcnt} >= SW'(st.hs[LO_MSB:LO_LSB]))
                  && ({1'b0, next_st.hcnt} < hs_end);
    next_st.vsync = next_st.vs_oe
                  && ({1'b0, next_st.vcnt} >= SW'(st.vs[LO_MSB:LO_LSB]))
                  && ({1'b0, next_st.vcnt} < vs_end);

    // Active area starts at the programmed offsets from blanking start.
    de_hend = SW'(st.bl[LO_MSB:LO_LSB]) + SW'(active_width_i);
    de_vend = SW'(st.bl[HI_MSB:HI_LSB]) + SW'(active_height_i);
    next_st.de = ({1'b0, next_st.hcnt} >= SW'(st.bl[LO_MSB:LO_LSB]))
              && ({1'b0, next_st.hcnt} < de_hend)
              && ({1'b0, next_st.vcnt} >= SW'(st.bl[HI_MSB:HI_LSB]))
              && ({1'b0, next_st.vcnt} < de_vend);

    // Pixel colour: palette only when enabled and not held by software.
    if (!next_st.de) begin
      next_st.color = REG_RST;
    end else if (st.pal_en && !st.pal_acc) begin
      next_st.color = pix_word;
    end else begin
      next_st.color = {PIX_FILL, pixel_index_i};
    end

    // Interrupt leads; a lead longer than a line is not supported.
    h_lead_pos = CNT_W'(total_width_i - CNT_W'(st.lead[LO_MSB:LO_LSB]));
    v_lead_pos = CNT_W'(total_width_i - CNT_W'(st.lead[HI_MSB:HI_LSB]));
    next_st.hirq = 1'b0;
    next_st.virq = 1'b0;
    if (tick) begin
      if (st.lead[LO_MSB:LO_LSB] == PIX_FILL) begin
        next_st.hirq = (next_st.hcnt == '0);
      end else begin
        next_st.hirq = (next_st.hcnt == h_lead_pos);
      end
      if (st.lead[HI_MSB:HI_LSB] == PIX_FILL) begin
        next_st.virq = (next_st.hcnt == '0) && (next_st.vcnt == '0);
      end else begin
        next_st.virq = (next_st.hcnt == v_lead_pos)
                    && (CNT_W'(next_st.vcnt + CNT_W'(1)) == total_height_i);
      end
    end

    // Panel power follows its request after the write value plus one display clocks.
    if (st.pwr == power_request_i) begin
      next_st.pwr_cnt = REG_RST;
    end else if (tick) begin
      if (st.pwr_cnt >= st.wdat) begin
        next_st.pwr = power_request_i;
        next_st.pwr_cnt = REG_RST;
      end else begin
        next_st.pwr_cnt = st.pwr_cnt + 16'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Palette memory is written in the busy cycle; no reset, as RAM.
  always_ff @(posedge core_clk_i) begin
    if (st.pal_op == DSPT_PAL_WR) begin
      pal_mem[st.pal_idx] <= st.wdat;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign hsync_o = st.hsync;
  assign vsync_o = st.vsync;
  assign display_enable_o = st.de;
  assign pixel_color_o = st.color;
  assign hblank_irq_o = st.hirq;
  assign vblank_irq_o = st.virq;
  assign panel_power_control_o = st.pwr;

  // Checks on the timing and palette behaviour.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic wr_ctl;
  logic wr_lo_only;
  assign wr_ctl = reg_wr_i && (reg_addr_i == REG_PALCTL);
  assign wr_lo_only = reg_wr_i && (reg_addr_i == REG_PALWR) && !reg_be_i[BE_HI_BIT];

  sequence s_rd_go;
    wr_ctl && reg_be_i[BE_HI_BIT] && !st.pal_trig
      && reg_wdata_i[PAL_TRIG_BIT] && reg_wdata_i[PAL_ACC_BIT];
  endsequence

  sequence s_busy_pulse;
    (st.pal_op == DSPT_PAL_RD) ##1 (st.pal_op == DSPT_PAL_IDLE);
  endsequence

  hs_gate_a: assert property (!st.hs_oe && !reg_wr_i |=> !hsync_o)
    else $error("hsync moved while disabled");
  vs_gate_a: assert property (!st.vs_oe && !reg_wr_i |=> !vsync_o)
    else $error("vsync moved while disabled");
  // An enable written mid-window raises hsync anywhere in it, so only steady settings are judged.
  hs_start_a: assert property ($rose(hsync_o) && $stable(st.hs) && $stable(st.hs_oe)
      |-> st.hcnt == CNT_W'(st.hs[LO_MSB:LO_LSB]))
    else $error("hsync started at wrong pixel");
  hs_width_a: assert property ($fell(hsync_o) && st.hs_oe && st.hcnt != '0 && $stable(st.hs)
      |-> {1'b0, st.hcnt} == hs_end)
    else $error("hsync width wrong");
  vs_start_a: assert property ($rose(vsync_o) && $stable(st.vs) && $stable(st.vs_oe)
      |-> st.vcnt == CNT_W'(st.vs[LO_MSB:LO_LSB]))
    else $error("vsync started at wrong line");
  hirq_pos_a: assert property (hblank_irq_o && st.lead[LO_MSB:LO_LSB] != PIX_FILL && $stable(st.lead)
      |-> st.hcnt == h_lead_pos)
    else $error("horizontal interrupt at wrong pixel");
  virq_pos_a: assert property (vblank_irq_o && st.lead[HI_MSB:HI_LSB] != PIX_FILL && $stable(st.lead)
      |-> ({1'b0, st.hcnt} + SW'(st.lead[HI_MSB:HI_LSB]) == {1'b0, total_width_i})
      && ({1'b0, st.vcnt} + SW'(1) == {1'b0, total_height_i}))
    else $error("vertical interrupt at wrong pixel");
  de_start_a: assert property (display_enable_o && $stable(st.bl)
      |-> st.hcnt >= CNT_W'(st.bl[LO_MSB:LO_LSB]) && st.vcnt >= CNT_W'(st.bl[HI_MSB:HI_LSB]))
    else $error("active area before offsets");
  pal_read_a: assert property (s_rd_go |=> s_busy_pulse ##0 st.rdat == $past(pal_word))
    else $error("triggered palette read failed");
  pal_lowbyte_a: assert property (wr_lo_only && !wr_ctl |=> st.pal_op != DSPT_PAL_WR)
    else $error("low byte write started palette write");
  pal_bypass_a: assert property (st.pal_acc && st.de
      |=> pixel_color_o[HI_MSB:HI_LSB] == PIX_FILL || !display_enable_o)
    else $error("display used palette while locked");

endmodule

`default_nettype wire

// ==== dspt_panel_model.sv ====
/*
  Panel-side model: makes the free-running display clock and measures the
  sync and enable widths that the panel sees, in display clocks (vsync in lines).
  Assumes the outputs settle well within one display clock period.
*/
`timescale 1ns/10ps
`default_nettype none
module dspt_panel_model (
  output logic pixel_clock_o,
  input wire logic hsync_i,
  input wire logic vsync_i,
  input wire logic de_i,
  output logic [7:0] hs_w_o,
  output logic [7:0] de_w_o,
  output logic [7:0] gap_o,
  output logic [7:0] vs_w_o
);
  logic hs_q = 1'b0;
  logic de_q = 1'b0;
  logic [7:0] hs_n = 8'h00;
  logic [7:0] de_n = 8'h00;
  logic [7:0] gap_n = 8'h00;
  logic [7:0] vs_n = 8'h00;

  // A panel's dot clock runs free, so it does not stop between frames.
  initial begin
    pixel_clock_o = 1'b0;
    forever #100 pixel_clock_o = ~pixel_clock_o;
  end

  // Each edge sees what the previous display clock produced, which avoids racing the synchroniser.
  always @(posedge pixel_clock_o) begin
    hs_q <= hsync_i;
    de_q <= de_i;
    hs_n <= hsync_i ? hs_n + 8'h01 : 8'h00;
    de_n <= de_i ? de_n + 8'h01 : 8'h00;
    gap_n <= (hsync_i && !hs_q) ? 8'h00 : gap_n + 8'h01;
    if (hs_q && !hsync_i) begin
      hs_w_o <= hs_n;
    end
    if (de_q && !de_i) begin
      de_w_o <= de_n;
    end
    if (de_i && !de_q) begin
      gap_o <= gap_n + 8'h01;
    end
    if (hsync_i && !hs_q) begin
      vs_n <= vsync_i ? vs_n + 8'h01 : 8'h00;
      if (!vsync_i && vs_n != 8'h00) begin
        vs_w_o <= vs_n;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test_display_sync_palette_timing.sv ====
/*
  Self-checking bench for the display timing and palette block.
  Assumes the panel model makes the display clock at 200 ns.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_display_sync_palette_timing;
  import dspt_pkg::*;
  typedef struct {logic [3:0] a; logic [15:0] d; logic [1:0] be; logic [15:0] ex;} dspt_row_s;
  logic clk, rst_n, wr, rd, pix, preq, hs, vs, de, hirq, virq, pwr, pq;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, color, d;
  logic [1:0] be;
  logic [7:0] pidx, hs_w, de_w, gap, vs_w;
  int failures = 0;
  int check_count = 0;
  int hs_hi, vs_hi, irq_n, irq_de, vb_n, n;
  dspt_row_s rows [8] = '{'{REG_HSYNC, 16'h0302, 2'h3, 16'h0302}, '{REG_VSYNC, 16'h0201, 2'h3, 16'h0201},
    '{REG_BLANK, 16'h0204, 2'h3, 16'h0204}, '{REG_LEAD, 16'h12FF, 2'h1, 16'h00FF},
    '{REG_LEAD, 16'h0000, 2'h3, 16'h0000}, '{REG_CTRL3, 16'h0003, 2'h3, 16'h0003},
    '{REG_PALRD, 16'h5A5A, 2'h3, 16'h0000}, '{4'h9, 16'h7777, 2'h3, 16'h0000}};
  logic [15:0] cmode [3] = '{16'h8005, 16'h0005, 16'h8105};
  logic [15:0] cexp [3] = '{16'hABCD, 16'h0005, 16'h0005};

  dspt_timing #(.CNT_W(11)) dspt_timing_i (.core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_be_i(be), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pixel_clock_i(pix), .total_width_i(11'h00A), .total_height_i(11'h005), .active_width_i(11'h004),
    .active_height_i(11'h002), .pixel_index_i(pidx), .power_request_i(preq), .hsync_o(hs), .vsync_o(vs),
    .display_enable_o(de), .pixel_color_o(color), .hblank_irq_o(hirq), .vblank_irq_o(virq),
    .panel_power_control_o(pwr));
  dspt_panel_model dspt_panel_model_i (.pixel_clock_o(pix), .hsync_i(hs), .vsync_i(vs), .de_i(de),
    .hs_w_o(hs_w), .de_w_o(de_w), .gap_o(gap), .vs_w_o(vs_w));

  // Core clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Activity counters, cleared on a falling edge so they never race their own updates.
  always @(posedge clk) begin
    hs_hi <= hs_hi + int'(hs);
    vs_hi <= vs_hi + int'(vs);
    irq_n <= irq_n + int'(hirq);
    irq_de <= irq_de + int'(hirq && de);
    vb_n <= vb_n + int'(virq);
  end

  task automatic clr_wait();
    @(negedge clk);
    {hs_hi, vs_hi, irq_n, irq_de, vb_n} = '0;
    repeat (800) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v, input logic [1:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    be <= b;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Starts at once, so it may follow a write with no gap.
  task automatic rd_now(input logic [3:0] a, output logic [15:0] q);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    q = rdata;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk);
    rd_now(a, q);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang costs far more than the fewer than 5000 cycles the sequence needs.
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial begin
    {rst_n, wr, rd, preq, addr, wdata, be} = '0;
    pidx = 8'h05;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d, rows[i].be);
      rd_reg(rows[i].a, d);
      `CHK("register", rows[i].ex, d)
    end
    clr_wait();
    `CHK("hsync width", 8'h03, hs_w)
    `CHK("enable width", 8'h04, de_w)
    `CHK("hsync to pixel", 8'h02, gap)
    `CHK("vsync lines", 8'h02, vs_w)
    `CHK("hblank irq", 1'b1, irq_n > 0)
    `CHK("hblank irq at zero lead", 0, irq_de)
    `CHK("vblank irq", 1'b1, vb_n inside {[1:3]})
    wr_reg(REG_LEAD, 16'h0304, 2'h3);
    clr_wait();
    `CHK("hblank irq lead", 1'b1, irq_de > 0)
    `CHK("vblank irq lead", 1'b1, vb_n inside {[1:3]})
    // Each sync enable alone must let only its own sync move.
    for (int k = 1; k < 3; k++) begin
      wr_reg(REG_CTRL3, 16'(k), 2'h1);
      clr_wait();
      `CHK("hsync moves", k[0], hs_hi > 0)
      `CHK("vsync moves", k[1], vs_hi > 0)
    end
    wr_reg(REG_PALCTL, 16'h0005, 2'h3);
    wr_reg(REG_PALWR, 16'hABCD, 2'h3);
    rd_now(REG_PALCTL, d);
    `CHK("busy set", 16'h4005, d)
    rd_reg(REG_PALCTL, d);
    `CHK("busy clear", 16'h0005, d)
    wr_reg(REG_PALCTL, 16'h0006, 2'h3);
    wr_reg(REG_PALWR, 16'h1234, 2'h3);
    wr_reg(REG_PALWR, 16'h0099, 2'h1);
    rd_reg(REG_PALWR, d);
    `CHK("write data lanes", 16'h1299, d)
    wr_reg(REG_PALCTL, 16'h0306, 2'h3);
    rd_reg(REG_PALRD, d);
    `CHK("entry six", 16'h1234, d)
    wr_reg(REG_PALCTL, 16'h0106, 2'h3);
    wr_reg(REG_PALCTL, 16'h0305, 2'h3);
    rd_reg(REG_PALRD, d);
    `CHK("entry five", 16'hABCD, d)
    wr_reg(REG_PALCTL, 16'h0006, 2'h3);
    wr_reg(REG_PALCTL, 16'h0206, 2'h3);
    rd_reg(REG_PALRD, d);
    `CHK("read without access", 16'hABCD, d)
    for (int i = 0; i < 3; i++) begin
      wr_reg(REG_PALCTL, cmode[i], 2'h3);
      repeat (4) @(posedge clk);
      for (int c = 0; c < 1000 && de !== 1'b1; c++) @(posedge clk);
      @(posedge clk);
      `CHK("pixel colour", cexp[i], color)
    end
    // Power follows the request after the write value plus one display clocks.
    // Raise the request just after a display clock has been taken in, so both sides count the same edges.
    wr_reg(REG_PALWR, 16'h0002, 2'h3);
    @(posedge pix);
    repeat (4) @(posedge clk);
    preq <= 1'b1;
    n = 0;
    pq = pix;
    for (int c = 0; c < 400 && pwr !== 1'b1; c++) begin
      @(posedge clk);
      n += int'(pix && !pq);
      pq = pix;
    end
    `CHK("power delay", 3, n)
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("power in reset", 1'b0, pwr)
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(4'(a), d);
      `CHK("reset value", REG_RST, d)
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
